// >>> rtl/ahm_pkg.sv
// constants, register indexes and state enums of the aux hub slot master
// assumes a 20 MHz system clock and an apb register port with 32-bit data
package ahm_pkg;

  // timing: scl rate and quarter-bit length in system clocks
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned SCL_KHZ    = 100;
  localparam int unsigned QTR_CYC    = CLK_HZ / (SCL_KHZ * 1000 * 4);

  // result storage depth
  localparam int unsigned RES_NUM    = 18;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_RES0                 = 8'h02;
  localparam logic [7:0] IDX_MCFG                 = 8'h14;
  localparam logic [7:0] IDX_SLOT0_TARGET_ADDRESS = 8'h15;
  localparam logic [7:0] IDX_SLOT0_START_REGISTER = 8'h16;
  localparam logic [7:0] IDX_SLOT0_READ_SETUP     = 8'h17;
  localparam logic [7:0] IDX_SLOT1_TARGET_ADDRESS = 8'h18;
  localparam logic [7:0] IDX_SLOT1_START_REGISTER = 8'h19;
  localparam logic [7:0] IDX_SLOT1_READ_SETUP     = 8'h1A;
  localparam logic [7:0] IDX_SLOT2_TARGET_ADDRESS = 8'h1B;
  localparam logic [7:0] IDX_SLOT2_START_REGISTER = 8'h1C;
  localparam logic [7:0] IDX_SLOT2_READ_SETUP     = 8'h1D;
  localparam logic [7:0] IDX_SLOT3_TARGET_ADDRESS = 8'h1E;
  localparam logic [7:0] IDX_SLOT3_START_REGISTER = 8'h1F;
  localparam logic [7:0] IDX_SLOT3_READ_SETUP     = 8'h20;
  localparam logic [7:0] IDX_SLOT0_WRITE_BYTE     = 8'h21;
  localparam logic [7:0] IDX_STATUS               = 8'h22;
  localparam logic [7:0] IDX_IRQ_STATUS           = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK             = 8'h31;

  localparam logic [3:0][7:0] IDX_TADR = {IDX_SLOT3_TARGET_ADDRESS,
    IDX_SLOT2_TARGET_ADDRESS, IDX_SLOT1_TARGET_ADDRESS,
    IDX_SLOT0_TARGET_ADDRESS};
  localparam logic [3:0][7:0] IDX_SREG = {IDX_SLOT3_START_REGISTER,
    IDX_SLOT2_START_REGISTER, IDX_SLOT1_START_REGISTER,
    IDX_SLOT0_START_REGISTER};
  localparam logic [3:0][7:0] IDX_SCFG = {IDX_SLOT3_READ_SETUP,
    IDX_SLOT2_READ_SETUP, IDX_SLOT1_READ_SETUP, IDX_SLOT0_READ_SETUP};

  // field positions
  localparam int unsigned MCFG_ON    = 2;   // master enable
  localparam int unsigned MCFG_TRIG  = 3;   // 1: external trigger pin
  localparam int unsigned ADR_RW     = 0;   // slot gate / slot0 direction
  localparam int unsigned CFG_BATCH  = 3;
  localparam logic [7:0]  CFG_WMASK  = 8'h0F;  // slots 1..3 upper bits zero
  localparam int unsigned IRQ_DONE   = 0;
  localparam int unsigned IRQ_NACK   = 1;
  localparam int unsigned IRQ_WDONE  = 2;

  // reset values
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic        DONE_RST   = 1'h1;

  typedef enum logic [2:0] {S_IDLE, S_NEXT, S_START, S_BIT, S_STOP}
    ahm_fsm_t;
  typedef enum logic [2:0] {OP_AW, OP_REG, OP_WD, OP_AR, OP_RD} ahm_op_t;

endpackage : ahm_pkg

// >>> rtl/ahm_slot_master.sv
// aux i2c master: four slot configs, trigger, bus engine, result registers
// assumes apb from the host, open-drain scl/sda resolved outside,
// drdy_tick a one-cycle pulse on clk, trig_pin asynchronous
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - slot address bits 7..1 hold target
// - address bit 0 gates slots 1 to 3
// - enabled reads wait for next trigger
// - start register gives first target register
// - setup bits 2..0 are read count
// - setup bit 3 pushes bytes to batching
// - slot0 write sends the write byte
// - read count registers from start address
// - slot count field limits served slots
// - results packed in order, no gaps
// - exactly eighteen byte result registers
// - slots served in order, codes select 1..4
// - slot0 bit 0: write or read
// - trigger source: data-ready or pin
// - done flag low while busy, high after
module ahm_slot_master #(
  parameter int unsigned QTR = ahm_pkg::QTR_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        drdy_tick,
  input  wire logic        trig_pin,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  output logic             batch_valid,
  output logic       [7:0] batch_data,
  output logic       [1:0] batch_slot,
  output logic             hub_routine_done,
  output logic             irq
);

  typedef struct packed {
    ahm_pkg::ahm_fsm_t fsm;
    ahm_pkg::ahm_op_t  op;
    logic [1:0]        q;
    logic [3:0]        bitn;
    logic [8:0]        sh;
    logic [8:0]        rx;
    logic [1:0]        slot;
    logic [2:0]        cnt;
    logic [4:0]        ptr;
    logic              sda_low;
    logic              scl_low;
    logic [1:0]        trig_s;
    logic              trig_d;
    logic [1:0]        sda_s;
    logic [15:0]       div;
    logic [3:0][7:0]   tadr;
    logic [3:0][7:0]   sreg;
    logic [3:0][7:0]   scfg;
    logic [7:0]        wbyte;
    logic [7:0]        mcfg;
    logic              done;
    logic [3:0]        nack;
    logic              wdone;
    logic [2:0]        ist;
    logic [2:0]        imsk;
    logic [17:0][7:0]  res;
    logic [31:0]       rdata;
    logic              bv;
    logic [7:0]        bd;
    logic [1:0]        bs;
  } ahm_state_t;

  ahm_state_t s_q;
  ahm_state_t s_d;

  logic [7:0] idx;
  logic       wr_acc;
  logic       tick;
  logic       trig;
  logic       byte_end;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // result registers sit at consecutive indexes
  function automatic logic is_res(input logic [7:0] i);
    return (i >= ahm_pkg::IDX_RES0) &&
           (i < 8'(ahm_pkg::IDX_RES0 + 8'(ahm_pkg::RES_NUM)));
  endfunction : is_res

  function automatic logic mapped(input logic [7:0] i);
    logic hit;
    hit = is_res(i) || i == ahm_pkg::IDX_MCFG ||
          i == ahm_pkg::IDX_SLOT0_WRITE_BYTE || i == ahm_pkg::IDX_STATUS ||
          i == ahm_pkg::IDX_IRQ_STATUS || i == ahm_pkg::IDX_IRQ_MASK;
    for (int k = 0; k < 4; k++) begin
      if (i == ahm_pkg::IDX_TADR[k] || i == ahm_pkg::IDX_SREG[k] ||
          i == ahm_pkg::IDX_SCFG[k]) begin
        hit = 1'h1;
      end
    end
    return hit;
  endfunction : mapped

  // status layout: write-done, per-slot nack, done in bit 0
  function automatic logic [31:0] rd_mux(input ahm_state_t s,
                                         input logic [7:0] i);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (is_res(i)) begin
      v[7:0] = s.res[5'(i - ahm_pkg::IDX_RES0)];
    end
    if (i == ahm_pkg::IDX_MCFG)             v[7:0] = s.mcfg;
    if (i == ahm_pkg::IDX_SLOT0_WRITE_BYTE) v[7:0] = s.wbyte;
    if (i == ahm_pkg::IDX_STATUS) begin
      v[7:0] = {s.wdone, s.nack, 2'h0, s.done};
    end
    if (i == ahm_pkg::IDX_IRQ_STATUS)       v[2:0] = s.ist;
    if (i == ahm_pkg::IDX_IRQ_MASK)         v[2:0] = s.imsk;
    for (int k = 0; k < 4; k++) begin
      if (i == ahm_pkg::IDX_TADR[k]) v[7:0] = s.tadr[k];
      if (i == ahm_pkg::IDX_SREG[k]) v[7:0] = s.sreg[k];
      if (i == ahm_pkg::IDX_SCFG[k]) v[7:0] = s.scfg[k];
    end
    return v;
  endfunction : rd_mux

  // slot gating: slot0 write always runs, reads need a count
  function automatic logic slot_go(input ahm_state_t s, input logic [1:0] k);
    logic rw;
    rw = s.tadr[k][ahm_pkg::ADR_RW];
    if (k == 2'h0 && !rw) begin
      return 1'h1;
    end
    // zero read count skips the slot entirely
    return rw && (s.scfg[k][2:0] != 3'h0);
  endfunction : slot_go

  //////////////////////////////////////////////////////////////////////////
  // bus decode and pacing

  assign idx      = paddr[9:2];
  assign wr_acc   = psel && penable && pwrite;
  assign tick     = (s_q.div == 16'(QTR - 1));
  assign byte_end = tick && s_q.q == 2'h3 && s_q.bitn == 4'h8;
  // pin path is edge-detected after the synchroniser
  assign trig = s_q.mcfg[ahm_pkg::MCFG_TRIG] ? (s_q.trig_s[1] && !s_q.trig_d)
                                               : drdy_tick;

  //////////////////////////////////////////////////////////////////////////
  // next state

  // registers, bus engine and flags all in one pass; sets come after w1c
  always_comb begin
    s_d    = s_q;
    s_d.bv = 1'h0;
    s_d.div    = tick ? 16'h0000 : 16'(s_q.div + 16'h0001);
    s_d.trig_s = {s_q.trig_s[0], trig_pin};
    s_d.trig_d = s_q.trig_s[1];
    s_d.sda_s  = {s_q.sda_s[0], sda_i};

    // apb: read data latched in setup, writes land in access
    if (psel && !penable) begin
      s_d.rdata = rd_mux(s_q, idx);
    end
    if (wr_acc) begin
      if (idx == ahm_pkg::IDX_MCFG)             s_d.mcfg  = pwdata[7:0];
      if (idx == ahm_pkg::IDX_SLOT0_WRITE_BYTE) s_d.wbyte = pwdata[7:0];
      if (idx == ahm_pkg::IDX_IRQ_MASK)         s_d.imsk  = pwdata[2:0];
      if (idx == ahm_pkg::IDX_IRQ_STATUS) begin
        s_d.ist = s_q.ist & ~pwdata[2:0];
      end
      for (int k = 0; k < 4; k++) begin
        if (idx == ahm_pkg::IDX_TADR[k]) s_d.tadr[k] = pwdata[7:0];
        if (idx == ahm_pkg::IDX_SREG[k]) s_d.sreg[k] = pwdata[7:0];
        // upper setup bits of slots 1..3 stay zero
        if (idx == ahm_pkg::IDX_SCFG[k]) begin
          s_d.scfg[k] = (k == 0) ? pwdata[7:0]
                                 : (pwdata[7:0] & ahm_pkg::CFG_WMASK);
        end
      end
    end

    case (s_q.fsm)
      ahm_pkg::S_IDLE: begin
        // nothing starts on configuration, only on a trigger
        if (s_q.mcfg[ahm_pkg::MCFG_ON] && trig) begin
          s_d.fsm  = ahm_pkg::S_NEXT;
          s_d.slot = 2'h0;
          s_d.ptr  = 5'h00;
          s_d.nack = 4'h0;
          // done drops for the whole routine
          s_d.done = 1'h0;
        end
      end
      ahm_pkg::S_NEXT: begin
        // one slot at a time, lowest first
        if (slot_go(s_q, s_q.slot)) begin
          s_d.fsm = ahm_pkg::S_START;
          s_d.q   = 2'h0;
          s_d.op  = ahm_pkg::OP_AW;
          s_d.cnt = s_q.scfg[s_q.slot][2:0];
        end else if (s_q.slot == s_q.mcfg[1:0]) begin
          s_d.fsm  = ahm_pkg::S_IDLE;
          s_d.done = 1'h1;
          s_d.ist[ahm_pkg::IRQ_DONE] = 1'h1;
        end else begin
          s_d.slot = s_q.slot + 2'h1;
        end
      end
      ahm_pkg::S_START: begin
        // start or repeated start; scl low on entry after a byte
        if (tick) begin
          s_d.q = s_q.q + 2'h1;
          case (s_q.q)
            2'h0: s_d.sda_low = 1'h0;
            2'h1: s_d.scl_low = 1'h0;
            2'h2: s_d.sda_low = 1'h1;
            default: begin
              s_d.scl_low = 1'h1;
              s_d.fsm     = ahm_pkg::S_BIT;
              s_d.bitn    = 4'h0;
              // address byte from bits 7..1, write then read
              s_d.sh = {s_q.tadr[s_q.slot][7:1],
                        s_q.op == ahm_pkg::OP_AR, 1'h1};
            end
          endcase
        end
      end
      ahm_pkg::S_BIT: begin
        if (tick) begin
          s_d.q = s_q.q + 2'h1;
          case (s_q.q)
            2'h0: s_d.sda_low = !s_q.sh[8];
            2'h1: s_d.scl_low = 1'h0;
            2'h2: s_d.rx = {s_q.rx[7:0], s_q.sda_s[1]};
            default: begin
              s_d.scl_low = 1'h1;
              s_d.sh      = {s_q.sh[7:0], 1'h1};
              s_d.bitn    = s_q.bitn + 4'h1;
            end
          endcase
        end
        if (byte_end) begin
          s_d.bitn = 4'h0;
          if (s_q.op != ahm_pkg::OP_RD && s_q.rx[0]) begin
            s_d.nack[s_q.slot]         = 1'h1;
            s_d.ist[ahm_pkg::IRQ_NACK] = 1'h1;
            s_d.fsm = ahm_pkg::S_STOP;
          end else begin
            case (s_q.op)
              ahm_pkg::OP_AW: begin
                s_d.op = ahm_pkg::OP_REG;
                s_d.sh = {s_q.sreg[s_q.slot], 1'h1};
              end
              ahm_pkg::OP_REG: begin
                // slot0 bit 0 low means a single write
                if (s_q.slot == 2'h0 && !s_q.tadr[0][ahm_pkg::ADR_RW]) begin
                  s_d.op = ahm_pkg::OP_WD;
                  // write byte goes to the start register
                  s_d.sh = {s_q.wbyte, 1'h1};
                end else begin
                  s_d.op  = ahm_pkg::OP_AR;
                  s_d.fsm = ahm_pkg::S_START;
                  s_d.q   = 2'h0;
                end
              end
              ahm_pkg::OP_WD: begin
                s_d.wdone = 1'h1;
                s_d.ist[ahm_pkg::IRQ_WDONE] = 1'h1;
                s_d.fsm = ahm_pkg::S_STOP;
              end
              ahm_pkg::OP_AR: begin
                // count bytes read; last one is not acked
                s_d.op = ahm_pkg::OP_RD;
                s_d.sh = {8'hFF, s_q.cnt == 3'h1};
              end
              default: begin
                // next free result register, no gaps
                // only eighteen slots, later bytes dropped
                if (s_q.ptr < 5'(ahm_pkg::RES_NUM)) begin
                  s_d.res[s_q.ptr] = s_q.rx[8:1];
                  s_d.ptr          = s_q.ptr + 5'h01;
                end
                // copy to the batching port when enabled
                s_d.bv = s_q.scfg[s_q.slot][ahm_pkg::CFG_BATCH];
                s_d.bd = s_q.rx[8:1];
                s_d.bs = s_q.slot;
                if (s_q.cnt == 3'h1) begin
                  s_d.fsm = ahm_pkg::S_STOP;
                end else begin
                  s_d.cnt = s_q.cnt - 3'h1;
                  s_d.sh  = {8'hFF, s_q.cnt == 3'h2};
                end
              end
            endcase
          end
          if (s_d.fsm == ahm_pkg::S_STOP) begin
            s_d.q = 2'h0;
          end
        end
      end
      ahm_pkg::S_STOP: begin
        if (tick) begin
          s_d.q = s_q.q + 2'h1;
          case (s_q.q)
            2'h0: s_d.sda_low = 1'h1;
            2'h1: s_d.scl_low = 1'h0;
            default: begin
              s_d.sda_low = 1'h0;
              // last slot is the one the count field names
              if (s_q.slot == s_q.mcfg[1:0]) begin
                s_d.fsm  = ahm_pkg::S_IDLE;
                s_d.done = 1'h1;
                s_d.ist[ahm_pkg::IRQ_DONE] = 1'h1;
              end else begin
                s_d.fsm  = ahm_pkg::S_NEXT;
                s_d.slot = s_q.slot + 2'h1;
              end
            end
          endcase
        end
      end
      default: s_d.fsm = ahm_pkg::S_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  // reset gives constants only; results clear here only, not when a routine starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q      <= '0;
      s_q.fsm  <= ahm_pkg::S_IDLE;
      s_q.op   <= ahm_pkg::OP_AW;
      s_q.mcfg <= ahm_pkg::REG_RST;
      s_q.done <= ahm_pkg::DONE_RST;
      s_q.sh   <= 9'h1FF;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; open drain only ever pulls low

  assign prdata           = s_q.rdata;
  assign pready           = 1'h1;
  assign pslverr          = psel && penable && !mapped(idx);
  assign scl_o            = 1'h0;
  assign scl_oe_n         = !s_q.scl_low;
  assign sda_o            = 1'h0;
  assign sda_oe_n         = !s_q.sda_low;
  assign batch_valid      = s_q.bv;
  assign batch_data       = s_q.bd;
  assign batch_slot       = s_q.bs;
  assign hub_routine_done = s_q.done;
  assign irq              = |(s_q.ist & s_q.imsk);

  //////////////////////////////////////////////////////////////////////////
  // checks

  done_busy_a: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm != ahm_pkg::S_IDLE |-> !hub_routine_done)
    else $error("done flag high while busy");

  trig_start_a: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm == ahm_pkg::S_IDLE && !(trig && s_q.mcfg[ahm_pkg::MCFG_ON])
    |=> s_q.fsm == ahm_pkg::S_IDLE)
    else $error("routine began without a trigger");

  addr_byte_a: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm == ahm_pkg::S_BIT && s_q.bitn == 4'h0 && s_q.q == 2'h0 &&
    s_q.op == ahm_pkg::OP_AW
    |-> s_q.sh[8:1] == {s_q.tadr[s_q.slot][7:1], 1'h0})
    else $error("wrong target address byte");

  write_byte_a: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm == ahm_pkg::S_BIT && s_q.bitn == 4'h0 && s_q.q == 2'h0 &&
    s_q.op == ahm_pkg::OP_WD |-> s_q.sh[8:1] == s_q.wbyte)
    else $error("wrong slot0 write byte");

  res_bound_a: assert property (@(posedge clk) disable iff (rst)
    s_q.ptr <= 5'(ahm_pkg::RES_NUM))
    else $error("result pointer past last register");

  res_order_a: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm != ahm_pkg::S_IDLE && $past(s_q.fsm) != ahm_pkg::S_IDLE &&
    s_q.ptr != $past(s_q.ptr)
    |-> s_q.ptr == 5'($past(s_q.ptr) + 5'h01) && s_q.res[$past(s_q.ptr)]
        == $past(s_q.rx[8:1], 2))
    else $error("result stored out of order");

  batch_gate_a: assert property (@(posedge clk) disable iff (rst)
    batch_valid |-> s_q.scfg[batch_slot][ahm_pkg::CFG_BATCH])
    else $error("batch push from a slot not enabled");

  slot_limit_a: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm == ahm_pkg::S_START |-> s_q.slot <= s_q.mcfg[1:0])
    else $error("slot beyond selected count served");

  slot_order_a: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm != ahm_pkg::S_IDLE && $past(s_q.fsm) != ahm_pkg::S_IDLE &&
    $changed(s_q.slot)
    |-> s_q.slot == $past(s_q.slot) + 2'h1)
    else $error("slot order broken");

  gate_off_a: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm == ahm_pkg::S_START && s_q.slot != 2'h0
    |-> s_q.tadr[s_q.slot][ahm_pkg::ADR_RW])
    else $error("disabled slot was read");

endmodule : ahm_slot_master
`default_nettype wire

// >>> test/ahm_sensor_model.sv
// i2c sensor targets: ack every address but one, serve reads, log writes
// assumes open-drain scl/sda wires with pull-ups resolved by the bench
`timescale 1ns/10ps
`default_nettype none
module ahm_sensor_model #(
  parameter logic [6:0] MISS = 7'h55
) (
  input  wire logic        scl,
  input  wire logic        sda,
  output logic             sda_pull,
  output logic      [23:0] last_wr,
  output int               wr_hits
);
  logic [7:0] sh, ptr, dat;
  logic [6:0] dev;
  logic       tx, go, rdm, ok;
  int         cnt, nb;
  initial begin
    sda_pull = 1'b0;
    wr_hits = 0;
    last_wr = 24'h0;
    tx = 1'b0;
    go = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // start resets framing, stop ends any read in flight
  always @(negedge sda) if (scl) begin
    cnt = 0;
    nb = 0;
    tx = 1'b0;
  end
  always @(posedge sda) if (scl) tx = 1'b0;
  // bits shift in on rising scl; a master nack ends a read
  always @(posedge scl) begin
    if (cnt == 8 && tx && sda) tx = 1'b0;
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  // bytes handled and data driven while scl is low, never while high
  always @(negedge scl) begin
    if (cnt == 8 && !tx) begin
      ok = 1'b1;
      if (nb == 0) begin
        dev = sh[7:1];
        rdm = sh[0];
        ok = (sh[7:1] != MISS);
        go = rdm && ok;
      end else if (nb == 1 && !rdm) ptr = sh;
      else begin
        last_wr = {1'b0, dev, ptr, sh};
        wr_hits++;
      end
      nb++;
      sda_pull = ok;
    end else if (cnt == 8) sda_pull = 1'b0;
    else if (cnt == 9) begin
      cnt = 0;
      tx = tx || go;
      go = 1'b0;
      sda_pull = 1'b0;
      if (tx) begin
        // content is a mix of target and register so both show
        dat = ptr ^ {dev[3:0], dev[6:4], 1'b1};
        ptr = ptr + 8'h01;
        sda_pull = ~dat[7];
      end
    end else if (tx) sda_pull = ~dat[7-cnt];
  end
endmodule : ahm_sensor_model
`default_nettype wire

// >>> test/ahm_slot_master_test.sv
// self-checking bench of the aux hub slot master against sensor targets
// assumes the design package, design and sensor model compiled first
`timescale 1ns/10ps
`default_nettype none
module ahm_slot_master_test;
  localparam logic [6:0] MISS = 7'h55;
  logic clk, rst, psel, penable, pwrite, drdy_tick, trig_pin, pull;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, e;
  logic batch_valid, hub_routine_done, irq, wdq;
  logic [7:0] batch_data, wbyte;
  logic [1:0] batch_slot, nsl;
  logic [23:0] last_wr;
  logic [7:0] adr[4], sreg[4], scfg[4], res[18];
  logic [9:0] bq[$];
  logic [2:0] msk;
  int wr_hits, num_errors, cmp_count, it, s, seed;
  wire logic scl_w = scl_oe_n ? 1'b1 : scl_o;
  wire logic sda_w = (sda_oe_n ? 1'b1 : sda_o) & ~pull;
  ahm_slot_master #(.QTR(2)) uut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drdy_tick(drdy_tick), .trig_pin(trig_pin), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .batch_valid(batch_valid),
    .batch_data(batch_data), .batch_slot(batch_slot),
    .hub_routine_done(hub_routine_done), .irq(irq));
  ahm_sensor_model #(.MISS(MISS)) sens (.scl(scl_w), .sda(sda_w),
    .sda_pull(pull), .last_wr(last_wr), .wr_hits(wr_hits));
  always #25 clk = ~clk;
  // batch pulses last one cycle, so every edge is watched
  always @(posedge clk) if (batch_valid === 1'b1)
    bq.push_back({batch_slot, batch_data});
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  // behavioural hub: slots in order, packed results, batch stream, flags
  task automatic routine(input logic pin);
    int p, k, n, h;
    logic [3:0] nk;
    logic wd;
    logic [7:0] d;
    logic [9:0] eq[$];
    p = 0;
    nk = 4'h0;
    wd = 1'b0;
    h = wr_hits;
    bq.delete();
    for (int t = 0; t <= nsl; t++) begin
      if (t == 0 && !adr[0][0]) wd = 1'b1;
      else if (adr[t][0] && scfg[t][2:0] != 3'h0) begin
        if (adr[t][7:1] == MISS) nk[t] = 1'b1;
        else for (k = 0; k < scfg[t][2:0]; k++) begin
          d = 8'(sreg[t] + k) ^ {adr[t][4:1], adr[t][7:5], 1'b1};
          if (scfg[t][3]) eq.push_back({2'(t), d});
          if (p < 18) res[p++] = d;
        end
      end
    end
    wdq = wdq | wd;
    apb(1'b1, ahm_pkg::IDX_MCFG, {28'h0, pin, 1'b1, nsl});
    repeat (6) @(posedge clk);
    chk(hub_routine_done, 1'b1);
    chk(scl_oe_n, 1'b1);
    if (pin) trig_pin <= 1'b1;
    else drdy_tick <= 1'b1;
    @(posedge clk);
    drdy_tick <= 1'b0;
    n = 0;
    while (hub_routine_done !== 1'b0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    trig_pin <= 1'b0;
    chk(hub_routine_done, 1'b0);
    n = 0;
    while (hub_routine_done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk(hub_routine_done, 1'b1);
    chk(irq, |(msk & {wd, |nk, 1'b1}));
    chk(bq.size(), eq.size());
    foreach (eq[i]) if (i < bq.size()) chk(bq[i], eq[i]);
    for (k = 0; k < 18; k++) begin
      apb(1'b0, 8'(ahm_pkg::IDX_RES0 + k), 32'h0);
      chk(v, {24'h0, res[k]});
    end
    apb(1'b0, ahm_pkg::IDX_STATUS, 32'h0);
    chk(v, {24'h0, wdq, nk, 3'h1});
    if (wd) chk(last_wr, {1'b0, adr[0][7:1], sreg[0], wbyte});
    chk(wr_hits, h + wd);
    apb(1'b0, ahm_pkg::IDX_IRQ_STATUS, 32'h0);
    chk(v, {29'h0, wd, |nk, 1'b1});
    apb(1'b1, ahm_pkg::IDX_IRQ_STATUS, 32'h7);
    @(posedge clk);
    chk(irq, 1'b0);
  endtask : routine
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    wrap_up;
  end
  initial begin
    {clk, psel, penable, pwrite, drdy_tick, trig_pin, wdq} = 7'h0;
    rst = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    seed = $urandom(91);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(hub_routine_done, 1'b1);
    apb(1'b1, ahm_pkg::IDX_STATUS, 32'hFF);
    apb(1'b0, ahm_pkg::IDX_STATUS, 32'h0);
    chk(v, 32'h1);
    apb(1'b0, 8'h3F, 32'h0);
    chk({e, v}, {1'b1, 32'h0});
    for (it = 0; it < 12; it++) begin
      // first pass packs all eighteen results, later ones are random
      adr = '{8'h21, 8'h23, 8'h25, 8'h27};
      sreg = '{8'h28, 8'h00, 8'h20, 8'h40};
      scfg = '{8'h03, 8'h0E, 8'h04, 8'h05};
      nsl = 2'h3;
      msk = 3'h1;
      wbyte = 8'($urandom);
      if (it > 0) begin
        for (s = 0; s < 4; s++) begin
          adr[s] = {($urandom % 5 == 0) ? MISS : 7'($urandom),
                    1'($urandom)};
          sreg[s] = 8'($urandom);
          scfg[s] = 8'($urandom);
        end
        if (!adr[0][0]) adr[0][7:1] = 7'h10;
        nsl = 2'($urandom);
        msk = 3'($urandom);
      end
      apb(1'b1, ahm_pkg::IDX_IRQ_MASK, {29'h0, msk});
      apb(1'b1, ahm_pkg::IDX_SLOT0_WRITE_BYTE, {24'h0, wbyte});
      for (s = 0; s < 4; s++) begin
        apb(1'b1, ahm_pkg::IDX_TADR[s], {24'h0, adr[s]});
        apb(1'b1, ahm_pkg::IDX_SREG[s], {24'h0, sreg[s]});
        apb(1'b1, ahm_pkg::IDX_SCFG[s], {24'h0, scfg[s]});
        if (s > 0) scfg[s] = scfg[s] & 8'h0F;
        apb(1'b0, ahm_pkg::IDX_SCFG[s], 32'h0);
        chk(v, {24'h0, scfg[s]});
        apb(1'b0, ahm_pkg::IDX_TADR[s], 32'h0);
        chk(v, {24'h0, adr[s]});
      end
      routine(it[0]);
    end
    wrap_up;
  end
endmodule : ahm_slot_master_test
`default_nettype wire
